// file: rtl/smt_config.sv
// system management routing, window decode and stop-clock control with ahb-lite registers
`timescale 1ns/10ps
`default_nettype none

module smt_config
    import smt_pkg::*;
#(
    parameter logic [31:0] TICK_CYCLES = 32'(IDLE_TICK_CYCLES),
    parameter logic [7:0] IDLE_RELOAD = IDLE_RELOAD_DEF
) (
    input wire logic clock_in,
    input wire logic srst_in,
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    output logic hreadyout_out,
    output logic hresp_out,
    output logic [31:0] hrdata_out,
    input wire logic legacy_irq_req_in,
    input wire logic sysmgmt_event_in,
    input wire logic system_event_in,
    input wire logic stop_grant_in,
    input wire logic break_event_in,
    input wire logic mem_valid_in,
    input wire logic [31:0] mem_addr_in,
    input wire logic io_valid_in,
    input wire logic [15:0] io_addr_in,
    output logic legacy_irq_out,
    output logic ioapic_shared_irq_out,
    output logic sysmgmt_irq_pin_n_out,
    output logic stop_clock_n_out,
    output logic window_index_sel_out,
    output logic window_data_sel_out,
    output logic bios_timer_hit_out,
    output logic irq_out
);

    function automatic logic reg_hit(input logic [31:0] a, input logic [7:0] idx);
        reg_hit = (a[31:10] == 22'h0) && (a[9:2] == idx) && (a[1:0] == 2'h0);
    endfunction

    logic [7:0] irq_path_q;
    logic [5:0] win_reloc_q;
    logic [15:0] bios_base_q;
    logic [7:0] sys_ctl_q;
    logic [7:0] pm_cmd_q;
    logic [7:0] scale_hi_q;
    logic [7:0] scale_lo_q;
    logic [EV_W-1:0] irq_status_q;
    logic [EV_W-1:0] irq_mask_q;
    logic wr_q;
    logic [31:0] addr_q;
    logic [31:0] hrdata_q;
    logic [31:0] rd_data_d;
    logic access;
    logic pm_command_reg_read;
    logic pm_write;
    logic ctl_write;
    logic stpen_clr;
    logic stpen_eff;
    smt_stop_e state_q;
    logic [7:0] dur_q;
    logic grant_seen_q;
    logic break_latched_q;
    logic wake;
    logic [31:0] tick_q;
    logic [7:0] idle_q;
    logic timeout;
    logic smi_cond;
    logic [EV_W-1:0] ev_set;

    // bus slave: zero wait, always okay
    assign access = hsel_in & htrans_in[1] & hready_in;
    assign hreadyout_out = 1'b1;
    assign hresp_out = 1'b0;
    assign hrdata_out = hrdata_q;

    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            wr_q <= 1'b0;
            addr_q <= 32'h0;
        end else begin
            wr_q <= access & hwrite_in;
            addr_q <= haddr_in;
        end
    end

    always_comb begin
        rd_data_d = 32'h0;
        // write-only registers fall to the zero default, no side effect
        if (reg_hit(haddr_in, IDX_BIOS_BASE)) begin
            rd_data_d = {16'h0, bios_base_q & (BIOS_ADDR_MASK | 16'h0001)};
        end else if (reg_hit(haddr_in, IDX_SYS_CTL)) begin
            rd_data_d = {24'h0, sys_ctl_q};
        end else if (reg_hit(haddr_in, IDX_PM_CMD)) begin
            rd_data_d = {24'h0, pm_cmd_q};
        end else if (reg_hit(haddr_in, IDX_SCALE_HI)) begin
            rd_data_d = {24'h0, scale_hi_q};
        end else if (reg_hit(haddr_in, IDX_SCALE_LO)) begin
            rd_data_d = {24'h0, scale_lo_q};
        end else if (reg_hit(haddr_in, IDX_IRQ_STATUS)) begin
            rd_data_d = {29'h0, irq_status_q};
        end else if (reg_hit(haddr_in, IDX_IRQ_MASK)) begin
            rd_data_d = {29'h0, irq_mask_q};
        end
    end

    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            hrdata_q <= 32'h0;
        end else if (access && !hwrite_in) begin
            hrdata_q <= rd_data_d;
        end else begin
            hrdata_q <= 32'h0;
        end
    end

    assign pm_command_reg_read = access & ~hwrite_in & reg_hit(haddr_in, IDX_PM_CMD);
    assign pm_write = wr_q & reg_hit(addr_q, IDX_PM_CMD);
    assign ctl_write = wr_q & reg_hit(addr_q, IDX_SYS_CTL);
    assign stpen_clr = pm_write | (ctl_write & ~hwdata_in[CTL_STOP_EN]);
    assign stpen_eff = sys_ctl_q[CTL_STOP_EN] & ~stpen_clr;

    // configuration registers
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            irq_path_q <= IRQ_PATH_RST;
            win_reloc_q <= WIN_RELOC_RST[5:0];
            bios_base_q <= BIOS_BASE_RST;
            pm_cmd_q <= 8'h0;
            scale_hi_q <= 8'h0;
            scale_lo_q <= 8'h0;
            irq_mask_q <= '0;
        end else if (wr_q) begin
            if (reg_hit(addr_q, IDX_IRQ_PATH)) begin
                irq_path_q <= {6'h0, hwdata_in[1:0]};
            end
            if (reg_hit(addr_q, IDX_WIN_RELOC)) begin
                win_reloc_q <= hwdata_in[5:0];
            end
            if (reg_hit(addr_q, IDX_BIOS_BASE)) begin
                bios_base_q <= hwdata_in[15:0] & (BIOS_ADDR_MASK | 16'h0001);
            end
            if (pm_write) begin
                pm_cmd_q <= hwdata_in[7:0];
            end
            if (reg_hit(addr_q, IDX_SCALE_HI)) begin
                scale_hi_q <= hwdata_in[7:0];
            end
            if (reg_hit(addr_q, IDX_SCALE_LO)) begin
                scale_lo_q <= hwdata_in[7:0];
            end
            if (reg_hit(addr_q, IDX_IRQ_MASK)) begin
                irq_mask_q <= hwdata_in[EV_W-1:0];
            end
        end
    end

    // control register; bits 4, 5 and 7 are dropped whatever software writes
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            sys_ctl_q <= SYS_CTL_RST;
        end else if (ctl_write) begin
            sys_ctl_q <= hwdata_in[7:0] & CTL_WR_MASK;
        end else if (pm_write) begin
            sys_ctl_q[CTL_STOP_EN] <= 1'b0;
        end
    end

    // idle countdown, one count per tick
    assign timeout = !sys_ctl_q[CTL_FREEZE] && (tick_q == TICK_CYCLES - 32'h1) && (idle_q <= 8'h1);

    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            tick_q <= 32'h0;
            idle_q <= IDLE_RELOAD;
        end else if (system_event_in) begin
            tick_q <= 32'h0;
            idle_q <= IDLE_RELOAD;
        end else if (!sys_ctl_q[CTL_FREEZE]) begin
            if (tick_q == TICK_CYCLES - 32'h1) begin
                tick_q <= 32'h0;
                idle_q <= (idle_q <= 8'h1) ? IDLE_RELOAD : idle_q - 8'h1;
            end else begin
                tick_q <= tick_q + 32'h1;
            end
        end
    end

    // sticky events, set beats a clearing write
    assign ev_set = {stop_grant_in, timeout, sysmgmt_event_in | timeout};

    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            irq_status_q <= '0;
        end else if (wr_q && reg_hit(addr_q, IDX_IRQ_STATUS)) begin
            irq_status_q <= (irq_status_q & ~hwdata_in[EV_W-1:0]) | ev_set;
        end else begin
            irq_status_q <= irq_status_q | ev_set;
        end
    end

    assign irq_out = |(irq_status_q & irq_mask_q);

    // smi and legacy interrupt routing
    assign smi_cond = irq_status_q[EV_SMI];
    assign sysmgmt_irq_pin_n_out = ~(smi_cond & sys_ctl_q[CTL_GATE] & ~irq_path_q[PATH_ROUTE]);
    // the controller input is shared, so smi displaces the legacy line
    assign ioapic_shared_irq_out = irq_path_q[PATH_ROUTE] ? smi_cond : legacy_irq_req_in;
    // masking relies on software keeping the controller enabled
    assign legacy_irq_out = legacy_irq_req_in & ~irq_path_q[PATH_IRQ_MASK];

    // window decodes, registered for clean timing
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            window_index_sel_out <= 1'b0;
            window_data_sel_out <= 1'b0;
            bios_timer_hit_out <= 1'b0;
        end else begin
            window_index_sel_out <= mem_valid_in && (mem_addr_in[31:16] == WIN_BASE_HI)
                && (mem_addr_in[15:10] == win_reloc_q)
                && (mem_addr_in[9:4] == WIN_INDEX_SLOT);
            window_data_sel_out <= mem_valid_in && (mem_addr_in[31:16] == WIN_BASE_HI)
                && (mem_addr_in[15:10] == win_reloc_q)
                && (mem_addr_in[9:4] == WIN_DATA_SLOT);
            bios_timer_hit_out <= io_valid_in && bios_base_q[BIOS_EN]
                && ((io_addr_in & BIOS_ADDR_MASK) == (bios_base_q & BIOS_ADDR_MASK));
        end
    end

    // stop grant and break latches live only outside the run state, through both the stop and high phases
    always_ff @(posedge clock_in) begin
        if (srst_in || state_q == ST_RUN) begin
            grant_seen_q <= 1'b0;
            break_latched_q <= 1'b0;
        end else begin
            grant_seen_q <= grant_seen_q | stop_grant_in;
            break_latched_q <= break_latched_q | break_event_in;
        end
    end

    // grant is taken from its latch, so a grant and break together wait a cycle
    assign wake = (break_latched_q | break_event_in)
        & (sys_ctl_q[CTL_NO_WAIT] | grant_seen_q);

    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            state_q <= ST_RUN;
            dur_q <= 8'h0;
        end else begin
            case (state_q)
                ST_RUN: begin
                    if (pm_command_reg_read && stpen_eff) begin
                        state_q <= ST_STOP;
                        dur_q <= scale_lo_q;
                    end
                end
                ST_STOP: begin
                    if (!stpen_eff || wake) begin
                        state_q <= ST_RUN;
                    end else if (sys_ctl_q[CTL_SCALE] && dur_q <= 8'h1) begin
                        state_q <= ST_HIGH;
                        dur_q <= scale_hi_q;
                    end else if (sys_ctl_q[CTL_SCALE]) begin
                        dur_q <= dur_q - 8'h1;
                    end
                end
                ST_HIGH: begin
                    if (!stpen_eff || wake || !sys_ctl_q[CTL_SCALE]) begin
                        state_q <= ST_RUN;
                    end else if (dur_q <= 8'h1) begin
                        state_q <= ST_STOP;
                        dur_q <= scale_lo_q;
                    end else begin
                        dur_q <= dur_q - 8'h1;
                    end
                end
                default: begin
                    state_q <= ST_RUN;
                end
            endcase
        end
    end

    assign stop_clock_n_out = (state_q != ST_STOP);

    default clocking cb @(posedge clock_in); endclocking
    default disable iff (srst_in);

    sequence s_stopped_waiting;
        state_q == ST_STOP && !sys_ctl_q[CTL_NO_WAIT] && !grant_seen_q
            && !sys_ctl_q[CTL_SCALE] && stpen_eff;
    endsequence

    sequence s_nowait_break;
        state_q == ST_STOP && sys_ctl_q[CTL_NO_WAIT] && break_event_in && stpen_eff;
    endsequence

    sequence s_scaled_low_end;
        state_q == ST_STOP && sys_ctl_q[CTL_SCALE] && stpen_eff && !wake && dur_q <= 8'h1;
    endsequence

    a_route_pin_off: assert property (irq_path_q[PATH_ROUTE] |-> sysmgmt_irq_pin_n_out)
        else $error("smi pin asserted while routed to controller");
    a_route_shared: assert property (irq_path_q[PATH_ROUTE] |-> ioapic_shared_irq_out == smi_cond)
        else $error("legacy interrupt leaked onto shared input");
    a_mask_legacy: assert property (irq_path_q[PATH_IRQ_MASK] |-> !legacy_irq_out)
        else $error("masked legacy interrupt active");
    a_bios_disabled: assert property (!bios_base_q[BIOS_EN] |=> !bios_timer_hit_out)
        else $error("bios timer hit while disabled");
    a_stop_negated: assert property (!sys_ctl_q[CTL_STOP_EN] |-> stop_clock_n_out)
        else $error("stop clock asserted while disabled");
    a_pm_command_reg_stop: assert property (state_q == ST_RUN && pm_command_reg_read && stpen_eff
        |=> !stop_clock_n_out)
        else $error("command read did not assert stop clock");
    a_pm_write_clr: assert property (pm_write && !ctl_write |=> !sys_ctl_q[CTL_STOP_EN])
        else $error("command write did not clear stop enable");
    a_freeze_hold: assert property (sys_ctl_q[CTL_FREEZE] && !system_event_in
        |=> $stable(idle_q) && $stable(tick_q))
        else $error("idle timer moved while frozen");
    a_grant_wait: assert property (s_stopped_waiting |=> !stop_clock_n_out)
        else $error("stop clock negated before stop grant");
    a_nowait_wake: assert property (s_nowait_break |=> stop_clock_n_out)
        else $error("stop clock not negated without grant wait");
    a_gate_pin: assert property (smi_cond && sys_ctl_q[CTL_GATE]
        && !irq_path_q[PATH_ROUTE] |-> !sysmgmt_irq_pin_n_out)
        else $error("gated pending smi not on pin");
    a_smi_record: assert property (sysmgmt_event_in |=> irq_status_q[EV_SMI])
        else $error("smi event not recorded");
    a_wo_read_zero: assert property (access && !hwrite_in
        && (reg_hit(haddr_in, IDX_IRQ_PATH) || reg_hit(haddr_in, IDX_WIN_RELOC))
        |=> hrdata_out == 32'h0)
        else $error("write-only register read nonzero");
    a_bit1_zero: assert property (access && !hwrite_in
        && reg_hit(haddr_in, IDX_BIOS_BASE) |=> !hrdata_out[1])
        else $error("bios base bit 1 read nonzero");
    a_mask_open: assert property (!irq_path_q[PATH_IRQ_MASK]
        |-> legacy_irq_out == legacy_irq_req_in)
        else $error("unmasked legacy interrupt not passed on");
    a_gate_closed: assert property (!sys_ctl_q[CTL_GATE] |-> sysmgmt_irq_pin_n_out)
        else $error("smi pin asserted while gate closed");
    a_win_index: assert property (mem_valid_in
        && mem_addr_in == {WIN_BASE_HI, win_reloc_q, WIN_INDEX_SLOT, 4'h0}
        |=> window_index_sel_out)
        else $error("relocated index window not decoded");
    a_win_data: assert property (mem_valid_in
        && mem_addr_in == {WIN_BASE_HI, win_reloc_q, WIN_DATA_SLOT, 4'h0}
        |=> window_data_sel_out)
        else $error("relocated data window not decoded");
    a_bios_match: assert property (io_valid_in && bios_base_q[BIOS_EN]
        && ((io_addr_in ^ bios_base_q) & BIOS_ADDR_MASK) == 16'h0 |=> bios_timer_hit_out)
        else $error("enabled bios timer window missed");
    a_timeout_smi: assert property (timeout
        |=> irq_status_q[EV_SMI] && irq_status_q[EV_TIMEOUT])
        else $error("idle timeout not recorded as smi");
    a_scale_high: assert property (s_scaled_low_end
        |=> stop_clock_n_out && dur_q == $past(scale_hi_q))
        else $error("scaled low time did not hand over to high time");

endmodule

`default_nettype wire

// file: rtl/smt_pkg.sv
// constants and types shared by the system management configuration block
package smt_pkg;

    // register indices; the byte address on the bus is four times the index
    localparam logic [7:0] IDX_IRQ_PATH = 8'h70;
    localparam logic [7:0] IDX_WIN_RELOC = 8'h71;
    localparam logic [7:0] IDX_BIOS_BASE = 8'h80;
    localparam logic [7:0] IDX_SYS_CTL = 8'ha0;
    localparam logic [7:0] IDX_PM_CMD = 8'h90;
    localparam logic [7:0] IDX_SCALE_HI = 8'h91;
    localparam logic [7:0] IDX_SCALE_LO = 8'h92;
    localparam logic [7:0] IDX_IRQ_STATUS = 8'h93;
    localparam logic [7:0] IDX_IRQ_MASK = 8'h94;

    // reset values
    localparam logic [7:0] IRQ_PATH_RST = 8'h00;
    localparam logic [7:0] WIN_RELOC_RST = 8'h00;
    localparam logic [15:0] BIOS_BASE_RST = 16'h0078;
    localparam logic [7:0] SYS_CTL_RST = 8'h08;

    // interrupt path config fields
    localparam int PATH_IRQ_MASK = 0;
    localparam int PATH_ROUTE = 1;

    // control register fields and writable bits
    localparam int CTL_GATE = 0;
    localparam int CTL_STOP_EN = 1;
    localparam int CTL_SCALE = 2;
    localparam int CTL_FREEZE = 3;
    localparam int CTL_NO_WAIT = 6;
    localparam logic [7:0] CTL_WR_MASK = 8'h4f;

    // bios_timer_window_base bits, reserved bit, enable bit
    localparam logic [15:0] BIOS_ADDR_MASK = 16'hfffc;
    localparam int BIOS_EN = 0;

    // interrupt controller memory window
    localparam logic [15:0] WIN_BASE_HI = 16'hfec0;
    localparam logic [5:0] WIN_INDEX_SLOT = 6'h00;
    localparam logic [5:0] WIN_DATA_SLOT = 6'h01;

    // interrupt status events
    localparam int EV_SMI = 0;
    localparam int EV_TIMEOUT = 1;
    localparam int EV_GRANT = 2;
    localparam int EV_W = 3;

    // idle timer: one count per minute
    localparam longint unsigned CLK_HZ = 64'd40_000_000;
    localparam longint unsigned IDLE_TICK_S = 64'd60;
    localparam longint unsigned IDLE_TICK_CYCLES = IDLE_TICK_S * CLK_HZ;
    localparam logic [7:0] IDLE_RELOAD_DEF = 8'h0f;

    typedef enum logic [1:0] {
        ST_RUN = 2'b00,
        ST_STOP = 2'b01,
        ST_HIGH = 2'b10
    } smt_stop_e;

endpackage

// file: dv/smt_host_model.sv
// host processor model answering stop clock with a stop grant cycle
`timescale 1ns/10ps
`default_nettype none
module smt_host_model (
    input wire logic clock_in,
    input wire logic srst_in,
    input wire logic stop_clock_n_in,
    input wire logic grant_en_in,
    input wire logic [3:0] grant_delay_in,
    output logic stop_grant_out
);
    logic [3:0] cnt_q;
    logic done_q;

    // one grant per stop assertion; a stalled cpu simply never grants
    always_ff @(posedge clock_in) begin
        if (srst_in || stop_clock_n_in) begin
            cnt_q <= 4'h0;
            done_q <= 1'b0;
            stop_grant_out <= 1'b0;
        end else begin
            stop_grant_out <= 1'b0;
            if (grant_en_in && !done_q) begin
                if (cnt_q == grant_delay_in) begin
                    stop_grant_out <= 1'b1;
                    done_q <= 1'b1;
                end else begin
                    cnt_q <= cnt_q + 4'h1;
                end
            end
        end
    end
endmodule
`default_nettype wire

// file: dv/smt_config_tb_top.sv
// self-checking bench for the system management configuration block
`timescale 1ns/10ps
`default_nettype none
module smt_config_tb_top import smt_pkg::*;;
    logic clk = 0, srst = 1, hsel = 0, hwrite = 0, mv = 0, iv = 0;
    logic lreq = 0, sev = 0, sysev = 0, brk = 0, gen = 0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, maddr = 32'h0;
    logic [15:0] iaddr = 16'h0;
    logic [3:0] gdly = 4'h2;
    logic hready, hresp, rdyq, lirq, shirq, pin_n, stop_n, isel, dsel, bhit, irq, grant;
    logic [31:0] hrdata, rdq;
    int failures = 0, num_checks = 0;

    initial begin
        forever #12.5 clk = ~clk;
    end

    // small counts keep the idle timer test short
    smt_config #(.TICK_CYCLES(32'd4), .IDLE_RELOAD(8'h02)) smt_config_i (
        .clock_in(clk), .srst_in(srst), .hsel_in(hsel), .haddr_in(haddr),
        .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'b010), .hwdata_in(hwdata),
        .hready_in(hready), .hreadyout_out(hready), .hresp_out(hresp),
        .hrdata_out(hrdata), .legacy_irq_req_in(lreq), .sysmgmt_event_in(sev),
        .system_event_in(sysev), .stop_grant_in(grant), .break_event_in(brk),
        .mem_valid_in(mv), .mem_addr_in(maddr), .io_valid_in(iv), .io_addr_in(iaddr),
        .legacy_irq_out(lirq), .ioapic_shared_irq_out(shirq),
        .sysmgmt_irq_pin_n_out(pin_n), .stop_clock_n_out(stop_n),
        .window_index_sel_out(isel), .window_data_sel_out(dsel),
        .bios_timer_hit_out(bhit), .irq_out(irq));

    smt_host_model smt_host_model_i (.clock_in(clk), .srst_in(srst),
        .stop_clock_n_in(stop_n), .grant_en_in(gen), .grant_delay_in(gdly),
        .stop_grant_out(grant));

    // copies taken at the edge avoid racing the slave's own updates
    always @(posedge clk) begin
        rdq <= hrdata;
        rdyq <= hready;
    end

    task automatic cyc;
        @(posedge clk);
        #1;
    endtask

    task automatic final_report;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic to;
        failures++;
        final_report();
    endtask

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected %s: expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic chkb(input string nm, input logic seen, input logic exp);
        chk(nm, {31'h0, seen}, {31'h0, exp});
    endtask

    task automatic bus(input logic w, input logic [7:0] ix, input logic [31:0] wd,
                       output logic [31:0] rd);
        int n;
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {22'h0, ix, 2'b00};
        hwrite <= w;
        for (n = 0; n < 20; n++) begin
            cyc();
            if (rdyq === 1'b1) break;
        end
        if (n == 20) to();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        for (n = 0; n < 20; n++) begin
            cyc();
            if (rdyq === 1'b1) break;
        end
        if (n == 20) to();
        rd = rdq;
    endtask

    task automatic wr(input logic [7:0] ix, input logic [31:0] d);
        logic [31:0] x;
        bus(1'b1, ix, d, x);
    endtask

    task automatic rdc(input string nm, input logic [7:0] ix, input logic [31:0] exp);
        logic [31:0] x;
        bus(1'b0, ix, 32'h0, x);
        chk(nm, x, exp);
        chkb("hresp", hresp, 1'b0);
    endtask

    // counts cycles at one stop clock level, bounded
    task automatic run(input logic lvl, output int n);
        for (n = 0; stop_n === lvl; n++) begin
            if (n == 60) to();
            cyc();
        end
    endtask

    task automatic io(input logic [15:0] a, input logic e);
        iv <= 1'b1;
        iaddr <= a;
        cyc();
        iv <= 1'b0;
        chkb("bios_hit", bhit, e);
    endtask

    task automatic win(input logic [31:0] a, input logic ei, input logic ed);
        mv <= 1'b1;
        maddr <= a;
        cyc();
        mv <= 1'b0;
        chkb("index_sel", isel, ei);
        chkb("data_sel", dsel, ed);
    endtask

    task automatic t_reset;
        rdc("path", IDX_IRQ_PATH, 32'h0);
        rdc("reloc", IDX_WIN_RELOC, 32'h0);
        rdc("bios", IDX_BIOS_BASE, {16'h0, BIOS_BASE_RST});
        rdc("ctl", IDX_SYS_CTL, {24'h0, SYS_CTL_RST});
        rdc("unmapped", 8'h3f, 32'h0);
        chkb("stop_n", stop_n, 1'b1);
        chkb("pin_n", pin_n, 1'b1);
        chkb("irq", irq, 1'b0);
        $display("test reset done");
    endtask

    task automatic t_regs;
        wr(IDX_SYS_CTL, 32'h7f); // bits 4 and 5 kept zero
        rdc("ctl", IDX_SYS_CTL, 32'h4f);
        wr(IDX_SYS_CTL, 32'h08);
        wr(IDX_BIOS_BASE, 32'hffff);
        rdc("bios", IDX_BIOS_BASE, 32'hfffd);
        wr(IDX_WIN_RELOC, 32'h3f);
        rdc("reloc", IDX_WIN_RELOC, 32'h0);
        $display("test regs done");
    endtask

    task automatic t_decode;
        io(16'hfffe, 1'b1);
        wr(IDX_BIOS_BASE, 32'h1234);
        io(16'h1234, 1'b0);
        wr(IDX_BIOS_BASE, 32'h1235);
        io(16'h1237, 1'b1);
        io(16'h1238, 1'b0);
        wr(IDX_WIN_RELOC, 32'h0);
        win(32'hfec00000, 1'b1, 1'b0);
        win(32'hfec00010, 1'b0, 1'b1);
        wr(IDX_WIN_RELOC, 32'h2d);
        win(32'hfec0b400, 1'b1, 1'b0);
        win(32'hfec0b410, 1'b0, 1'b1);
        win(32'hfec0b000, 1'b0, 1'b0);
        win(32'hfec03400, 1'b0, 1'b0);
        $display("test decode done");
    endtask

    task automatic t_path;
        lreq <= 1'b1;
        cyc();
        chkb("legacy", lirq, 1'b1);
        chkb("shared", shirq, 1'b1);
        wr(IDX_IRQ_PATH, 32'h1); // controller taken as enabled
        chkb("legacy", lirq, 1'b0);
        wr(IDX_SYS_CTL, 32'h09);
        wr(IDX_IRQ_MASK, 32'h1);
        sev <= 1'b1;
        cyc();
        sev <= 1'b0;
        cyc();
        chkb("pin_n", pin_n, 1'b0);
        chkb("irq", irq, 1'b1);
        wr(IDX_SYS_CTL, 32'h08);
        chkb("pin_n", pin_n, 1'b1);
        rdc("status", IDX_IRQ_STATUS, 32'h1);
        wr(IDX_IRQ_MASK, 32'h0);
        chkb("irq", irq, 1'b0);
        wr(IDX_IRQ_MASK, 32'h1);
        wr(IDX_IRQ_PATH, 32'h2);
        wr(IDX_SYS_CTL, 32'h09);
        chkb("shared", shirq, 1'b1);
        chkb("pin_n", pin_n, 1'b1);
        wr(IDX_IRQ_STATUS, 32'h1);
        chkb("shared", shirq, 1'b0);
        chkb("irq", irq, 1'b0);
        wr(IDX_IRQ_PATH, 32'h0);
        chkb("shared", shirq, 1'b1);
        chkb("legacy", lirq, 1'b1);
        lreq <= 1'b0;
        wr(IDX_SYS_CTL, 32'h08);
        $display("test path done");
    endtask

    task automatic t_stop;
        int n;
        gen <= 1'b0;
        wr(IDX_SYS_CTL, 32'h0a);
        rdc("pm", IDX_PM_CMD, 32'h0);
        chkb("stop_n", stop_n, 1'b0);
        brk <= 1'b1;
        cyc();
        brk <= 1'b0;
        repeat (4) cyc();
        chkb("stop_n", stop_n, 1'b0);
        gen <= 1'b1;
        run(1'b0, n);
        chkb("stop_n", stop_n, 1'b1);
        gen <= 1'b0;
        wr(IDX_SYS_CTL, 32'h4a);
        rdc("pm", IDX_PM_CMD, 32'h0);
        chkb("stop_n", stop_n, 1'b0);
        brk <= 1'b1;
        cyc();
        brk <= 1'b0;
        cyc();
        chkb("stop_n", stop_n, 1'b1);
        wr(IDX_PM_CMD, 32'h0);
        rdc("ctl", IDX_SYS_CTL, 32'h48);
        rdc("pm", IDX_PM_CMD, 32'h0);
        chkb("stop_n", stop_n, 1'b1);
        $display("test stop done");
    endtask

    task automatic t_scale;
        int n, h, l;
        wr(IDX_SCALE_HI, 32'h2);
        wr(IDX_SCALE_LO, 32'h3);
        wr(IDX_SYS_CTL, 32'h0e);
        rdc("pm", IDX_PM_CMD, 32'h0);
        run(1'b0, n);
        run(1'b1, h);
        run(1'b0, l);
        chk("high_time", 32'(h), 32'h2);
        chk("low_time", 32'(l), 32'h3);
        wr(IDX_SYS_CTL, 32'h08); // zero write drops stop enable
        cyc();
        chkb("stop_n", stop_n, 1'b1);
        $display("test scale done");
    endtask

    task automatic t_timer;
        wr(IDX_IRQ_STATUS, 32'h7);
        repeat (40) cyc();
        rdc("status", IDX_IRQ_STATUS, 32'h0);
        sysev <= 1'b1; // activity keeps reloading the count
        wr(IDX_SYS_CTL, 32'h00);
        repeat (40) cyc();
        rdc("status", IDX_IRQ_STATUS, 32'h0);
        sysev <= 1'b0;
        repeat (40) cyc();
        rdc("status", IDX_IRQ_STATUS, 32'h3);
        wr(IDX_SYS_CTL, 32'h08);
        $display("test timer done");
    endtask

    initial begin
        repeat (12) cyc();
        srst <= 1'b0;
        cyc();
        t_reset();
        t_regs();
        t_decode();
        t_path();
        t_stop();
        t_scale();
        t_timer();
        final_report();
    end
endmodule
`default_nettype wire
